// ==== logic/ismt_defs.vh ====
// Constants for the indirect access decoder and static address table.
// Assumes a byte-wide management register port driven on the core clock.
// Notes on behaviour
// R1: Class 000 table 11 maps to MIB counters; port 3 at 0x040, totals at 0x100.
// R2: Class 001 gives six 16-bit EEE registers per port via the byte register.
// R3: Class 010 gives sixteen ACL entries per port, two addresses each.
// R4: Classes 011 and 101 are factory reserved; the master does not use them.
// R5: Class 100 gives config and wake registers; selector 0 global, 1 to 4 ports.
// R6: Port sits in indirect address bits 11-8, taken from control bits 3-0; low bits from the index write.
// R7: A destination look-up searches both static and dynamic tables.
// R8: A source look-up searches only the dynamic table.
// R9: When both tables match a destination, the static result wins.
// R10: Only the external master adds, changes or deletes static entries.
// R11: The device never ages out or removes static entries itself.
// R12: Read and write bit layouts of a static entry differ.
// R13: Read bits 63-57 give the filter tag; bit 55 reads as reserved.
// R14: Read bit 56 tells whether the key includes the filter tag.
// R15: Bit 54 set overrides spanning-tree transmit or receive disables.
// R16: A static entry is used only when its bit 53 is set.
// R17: Bits 52-48 are per-port forward mask, all ones broadcast; 47-0 address.
// R18: A read selects static read in control register, then writes the index.
// R19: A write loads eight data bytes, selects write, then writes the index.
// R20: With no valid static match, the dynamic result forwards the frame.
`ifndef ISMT_DEFS_VH
`define ISMT_DEFS_VH

// Direct register addresses
`define ISMT_A_CTRL       8'h6e
`define ISMT_A_INDEX      8'h6f
`define ISMT_A_DATA_FIRST 8'h71
`define ISMT_A_DATA_LAST  8'h78
`define ISMT_A_BYTE       8'ha0

// Control register fields
`define ISMT_CLASS_HI     7
`define ISMT_CLASS_LO     5
`define ISMT_RDSEL_BIT    4
`define ISMT_TSEL_HI      3
`define ISMT_TSEL_LO      2
`define ISMT_PORT_HI      3
`define ISMT_PORT_LO      0
`define ISMT_AHI_HI       1
`define ISMT_AHI_LO       0

// Access classes and table selections
`define ISMT_CL_TABLE     3'h0
`define ISMT_CL_EEE       3'h1
`define ISMT_CL_ACL       3'h2
`define ISMT_CL_RSV0      3'h3
`define ISMT_CL_CFG       3'h4
`define ISMT_CL_RSV1      3'h5
`define ISMT_TS_STATIC    2'h0
`define ISMT_TS_MIB       2'h3

// Indirect address limits
`define ISMT_EEE_COUNT    8'h06
`define ISMT_ACL_COUNT    8'h20
`define ISMT_CFG_PORTMAX  4'h4
`define ISMT_MIB_PORTEND  10'h0a0
`define ISMT_MIB_TOT_LO   10'h100
`define ISMT_MIB_TOT_HI   10'h113
`define ISMT_MIB_IDX_HI   4
`define ISMT_MIB_PRT_HI   7
`define ISMT_MIB_PRT_LO   5
`define ISMT_MIB_PRT_BASE 3'h1

// Static table geometry and stored (write) layout
`define ISMT_ENTRIES      32
`define ISMT_IDX_W        5
`define ISMT_ENT_W        63
`define ISMT_W_TAG_HI     62
`define ISMT_W_TAG_LO     56
`define ISMT_W_USE        55
`define ISMT_OVR          54
`define ISMT_VALID        53
`define ISMT_PORTS_HI     52
`define ISMT_PORTS_LO     48
`define ISMT_MAC_HI       47
`define ISMT_MAC_LO       0
`define ISMT_NBYTES       8
`define ISMT_RSV_READ     1'h0

`endif

// ==== logic/ismt_lookup.v ====
// Address look-up: static search and merge with the dynamic table answer.
// Assumes the dynamic answer arrives in the same cycle as the request.
`timescale 1ns/1ns
`include "ismt_defs.vh"

module ismt_lookup (
    // Clock and reset
    input  wire                                   clk,
    input  wire                                   resetn,
    // Static table contents, entry e at e*63
    input  wire [`ISMT_ENTRIES*`ISMT_ENT_W-1:0]   tbl_flat,
    // Request from the switch engine
    input  wire                                   da_req,
    input  wire                                   sa_req,
    input  wire [47:0]                            da_mac,
    input  wire [6:0]                             da_filter_tag,
    input  wire                                   dyn_hit,
    input  wire [4:0]                             dyn_ports,
    // Result
    output reg                                    fwd_valid_q,
    output reg  [4:0]                             fwd_ports_q,
    output reg                                    fwd_override_q,
    output reg                                    fwd_from_static_q,
    output reg                                    fwd_miss_q,
    output reg                                    sa_dyn_req_q
);

    wire [`ISMT_ENTRIES-1:0] hit;
    reg  [`ISMT_ENT_W-1:0]   sel_d;
    reg                      shit_d;
    integer                  i;

    // Per-entry match; tag compared only when the key includes it
    genvar e;
    generate
        for (e = 0; e < `ISMT_ENTRIES; e = e + 1) begin : g_match
            wire [`ISMT_ENT_W-1:0] ent = tbl_flat[e*`ISMT_ENT_W +: `ISMT_ENT_W];
            assign hit[e] = ent[`ISMT_VALID] // R16
                && (ent[`ISMT_MAC_HI:`ISMT_MAC_LO] == da_mac)
                && (!ent[`ISMT_W_USE] // R14
                    || (ent[`ISMT_W_TAG_HI:`ISMT_W_TAG_LO] == da_filter_tag));
        end
    endgenerate

    // Lowest index wins when several entries match
    always @* begin
        sel_d  = {`ISMT_ENT_W{1'b0}};
        shit_d = 1'b0;
        for (i = `ISMT_ENTRIES - 1; i >= 0; i = i - 1) begin
            if (hit[i]) begin
                sel_d  = tbl_flat[i*`ISMT_ENT_W +: `ISMT_ENT_W];
                shit_d = 1'b1;
            end
        end
    end

    // Result register; static searched only for destination look-ups
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fwd_valid_q       <= 1'b0;
            fwd_ports_q       <= 5'h00;
            fwd_override_q    <= 1'b0;
            fwd_from_static_q <= 1'b0;
            fwd_miss_q        <= 1'b0;
            sa_dyn_req_q      <= 1'b0;
        end else begin
            fwd_valid_q  <= da_req; // R7
            sa_dyn_req_q <= sa_req; // R8
            if (da_req && shit_d) begin
                fwd_ports_q       <= sel_d[`ISMT_PORTS_HI:`ISMT_PORTS_LO]; // R9 R17
                fwd_override_q    <= sel_d[`ISMT_OVR]; // R15
                fwd_from_static_q <= 1'b1;
                fwd_miss_q        <= 1'b0;
            end else if (da_req) begin
                fwd_ports_q       <= dyn_hit ? dyn_ports : 5'h00; // R20
                fwd_override_q    <= 1'b0;
                fwd_from_static_q <= 1'b0;
                fwd_miss_q        <= !dyn_hit;
            end
        end
    end

endmodule

// ==== logic/ismt_top.v ====
// Indirect access decoder with the static destination address table.
// Assumes a management port on clk and an engine that gives look-ups on clk.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "ismt_defs.vh"

module ismt_top (
    // Clock and reset
    input  wire         clk,
    input  wire         resetn,
    // Management register port
    input  wire [7:0]   reg_addr,
    input  wire [7:0]   reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [7:0]   reg_rdata_q,
    // Indirect access to the port-qualified spaces
    output reg          ind_strobe_q,
    output reg          ind_write_q,
    output reg  [2:0]   ind_class_q,
    output reg  [3:0]   ind_port_q,
    output reg  [7:0]   ind_offset_q,
    output reg  [7:0]   ind_wdata_q,
    input  wire [7:0]   ind_rdata,
    // MIB counter select
    output reg          mib_sel_q,
    output reg  [2:0]   mib_port_q,
    output reg  [4:0]   mib_index_q,
    output reg          mib_total_q,
    // Look-up request from the engine
    input  wire         da_req,
    input  wire         sa_req,
    input  wire [47:0]  da_mac,
    input  wire [6:0]   da_filter_tag,
    input  wire         dyn_hit,
    input  wire [4:0]   dyn_ports,
    // Look-up result
    output wire         fwd_valid_q,
    output wire [4:0]   fwd_ports_q,
    output wire         fwd_override_q,
    output wire         fwd_from_static_q,
    output wire         fwd_miss_q,
    output wire         sa_dyn_req_q
);

    // Decode of an indirect access: 1 when the address lies inside a
    // space that this block passes on; reserved spaces give 0
    function ind_ok;
        input [2:0] cls;
        input [3:0] port;
        input [7:0] off;
        begin
            case (cls)
                `ISMT_CL_EEE:  ind_ok = (off < `ISMT_EEE_COUNT);
                `ISMT_CL_ACL:  ind_ok = (off < `ISMT_ACL_COUNT);
                `ISMT_CL_CFG:  ind_ok = (port <= `ISMT_CFG_PORTMAX);
                `ISMT_CL_RSV0: ind_ok = 1'b0;
                `ISMT_CL_RSV1: ind_ok = 1'b0;
                default:       ind_ok = 1'b0;
            endcase
        end
    endfunction

    // Byte lane of a data register, 0 for the top byte
    function [2:0] lane_of;
        input [7:0] a;
        reg   [7:0] d;
        begin
            d       = a - `ISMT_A_DATA_FIRST;
            lane_of = d[2:0];
        end
    endfunction

    // Register state
    reg  [7:0]  ctrl_q;
    reg  [7:0]  index_q;
    reg  [7:0]  byte_q;
    reg  [63:0] wbuf_q;
    reg  [63:0] rbuf_q;
    reg         ind_rd_pend_q;
    reg  [`ISMT_ENT_W-1:0] tbl_q [0:`ISMT_ENTRIES-1];

    // Field views of the control register
    wire [2:0]  cls      = ctrl_q[`ISMT_CLASS_HI:`ISMT_CLASS_LO];
    wire [1:0]  tsel     = ctrl_q[`ISMT_TSEL_HI:`ISMT_TSEL_LO];
    wire        rd_sel   = ctrl_q[`ISMT_RDSEL_BIT];
    wire [3:0]  port_sel = ctrl_q[`ISMT_PORT_HI:`ISMT_PORT_LO]; // R6
    wire [9:0]  tbl_addr = {ctrl_q[`ISMT_AHI_HI:`ISMT_AHI_LO], reg_wdata};

    // Bus decodes
    wire        wr_ctrl  = reg_wr && (reg_addr == `ISMT_A_CTRL);
    wire        trigger  = reg_wr && (reg_addr == `ISMT_A_INDEX);
    wire        wr_byte  = reg_wr && (reg_addr == `ISMT_A_BYTE);
    wire        in_data  = (reg_addr >= `ISMT_A_DATA_FIRST)
                        && (reg_addr <= `ISMT_A_DATA_LAST);
    wire [2:0]  lane     = lane_of(reg_addr);
    wire [`ISMT_IDX_W-1:0] ent_idx = reg_wdata[`ISMT_IDX_W-1:0];

    // Kinds of trigger
    wire        is_table = (cls == `ISMT_CL_TABLE);
    wire        st_trig  = trigger && is_table && (tsel == `ISMT_TS_STATIC)
                        && (tbl_addr < `ISMT_ENTRIES);
    wire        mib_trig = trigger && is_table && (tsel == `ISMT_TS_MIB);
    wire        prt_trig = trigger && !is_table && ind_ok(cls, port_sel, reg_wdata);

    // MIB address split: ports 1..5 in 32-word blocks, totals from 0x100
    wire        mib_in_port = (tbl_addr < `ISMT_MIB_PORTEND);
    wire        mib_in_tot  = (tbl_addr >= `ISMT_MIB_TOT_LO)
                           && (tbl_addr <= `ISMT_MIB_TOT_HI);
    wire [2:0]  mib_port_d  = tbl_addr[`ISMT_MIB_PRT_HI:`ISMT_MIB_PRT_LO]
                           + `ISMT_MIB_PRT_BASE;

    // Entry packed in the read layout for the selected index
    wire [`ISMT_ENT_W-1:0] rd_ent = tbl_q[ent_idx];
    wire [63:0] rd_layout = {rd_ent[`ISMT_W_TAG_HI:`ISMT_W_TAG_LO], // R13
                             rd_ent[`ISMT_W_USE], // R14
                             `ISMT_RSV_READ, // R13
                             rd_ent[`ISMT_OVR:`ISMT_MAC_LO]}; // R12

    // Control and index registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q  <= 8'h00;
            index_q <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata; // R18 R19
            end
            if (trigger) begin
                index_q <= reg_wdata;
            end
        end
    end

    // Write data bytes are staged here; nothing moves until the trigger
    genvar b;
    generate
        for (b = 0; b < `ISMT_NBYTES; b = b + 1) begin : g_wbuf
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    wbuf_q[63-8*b -: 8] <= 8'h00;
                end else if (reg_wr && in_data && (lane == b)) begin
                    wbuf_q[63-8*b -: 8] <= reg_wdata; // R19
                end
            end
        end
    endgenerate

    // Static table; only the management port ever writes it, and no
    // aging path exists, so entries stay until software replaces them
    genvar t;
    generate
        for (t = 0; t < `ISMT_ENTRIES; t = t + 1) begin : g_tbl
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    tbl_q[t] <= {`ISMT_ENT_W{1'b0}};
                end else if (st_trig && !rd_sel && (ent_idx == t)) begin
                    tbl_q[t] <= wbuf_q[`ISMT_ENT_W-1:0]; // R10 R11 R12
                end
            end
        end
    endgenerate

    // Read buffer filled by a static read trigger
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rbuf_q <= 64'h0;
        end else if (st_trig && rd_sel) begin
            rbuf_q <= rd_layout; // R18
        end
    end

    // Indirect byte register; returning read data wins over a bus write
    // in the same cycle so a completed read is never lost
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            byte_q <= 8'h00;
        end else if (ind_rd_pend_q) begin
            byte_q <= ind_rdata; // R2 R3 R5
        end else if (wr_byte) begin
            byte_q <= reg_wdata;
        end
    end

    // Strobe to the port-qualified spaces; reserved classes stay silent
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ind_strobe_q  <= 1'b0;
            ind_write_q   <= 1'b0;
            ind_class_q   <= 3'h0;
            ind_port_q    <= 4'h0;
            ind_offset_q  <= 8'h00;
            ind_wdata_q   <= 8'h00;
            ind_rd_pend_q <= 1'b0;
        end else begin
            ind_strobe_q  <= prt_trig; // R4
            ind_rd_pend_q <= prt_trig && rd_sel;
            if (prt_trig) begin
                ind_write_q  <= !rd_sel;
                ind_class_q  <= cls; // R2 R3 R5
                ind_port_q   <= port_sel; // R6
                ind_offset_q <= reg_wdata; // R6
                ind_wdata_q  <= byte_q;
            end
        end
    end

    // MIB select pulse with counter coordinates
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mib_sel_q   <= 1'b0;
            mib_port_q  <= 3'h0;
            mib_index_q <= 5'h00;
            mib_total_q <= 1'b0;
        end else begin
            mib_sel_q <= mib_trig && (mib_in_port || mib_in_tot); // R1
            if (mib_trig) begin
                mib_port_q  <= mib_in_port ? mib_port_d : 3'h0; // R1
                mib_index_q <= tbl_addr[`ISMT_MIB_IDX_HI:0];
                mib_total_q <= mib_in_tot; // R1
            end
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ISMT_A_CTRL) begin
                reg_rdata_q <= ctrl_q;
            end else if (reg_addr == `ISMT_A_INDEX) begin
                reg_rdata_q <= index_q;
            end else if (reg_addr == `ISMT_A_BYTE) begin
                reg_rdata_q <= byte_q;
            end else if (in_data) begin
                reg_rdata_q <= rbuf_q[63-8*lane -: 8]; // R12
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    // Flatten the table for the look-up unit
    wire [`ISMT_ENTRIES*`ISMT_ENT_W-1:0] tbl_flat;
    genvar f;
    generate
        for (f = 0; f < `ISMT_ENTRIES; f = f + 1) begin : g_flat
            assign tbl_flat[f*`ISMT_ENT_W +: `ISMT_ENT_W] = tbl_q[f];
        end
    endgenerate

    // Look-up unit; its outputs are its own flip-flops
    ismt_lookup u_lookup (
        .clk               (clk),
        .resetn            (resetn),
        .tbl_flat          (tbl_flat),
        .da_req            (da_req),
        .sa_req            (sa_req),
        .da_mac            (da_mac),
        .da_filter_tag     (da_filter_tag),
        .dyn_hit           (dyn_hit),
        .dyn_ports         (dyn_ports),
        .fwd_valid_q       (fwd_valid_q),
        .fwd_ports_q       (fwd_ports_q),
        .fwd_override_q    (fwd_override_q),
        .fwd_from_static_q (fwd_from_static_q),
        .fwd_miss_q        (fwd_miss_q),
        .sa_dyn_req_q      (sa_dyn_req_q)
    );

endmodule

// ==== tb/ismt_partner.sv ====
// Model of the indirect register spaces that answer the byte port.
// Assumes the decoder's indirect outputs arrive on the same clock.
`timescale 1ns/1ns
module ismt_partner (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Indirect access from the decoder
    input  wire       ind_strobe_q,
    input  wire       ind_write_q,
    input  wire [3:0] ind_port_q,
    input  wire [7:0] ind_offset_q,
    // Read answer
    output wire [7:0] ind_rdata
);
    reg [7:0] noise_q;

    // Changing pattern while idle, so a stale capture never looks right
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            noise_q <= 8'h00;
        else
            noise_q <= noise_q + 8'h3b;
    end

    // Answer only in the strobe cycle of a read; port and offset pick the byte
    assign ind_rdata = (ind_strobe_q && !ind_write_q) ?
                       ({ind_port_q, ind_offset_q[3:0]} ^ 8'h5a) : noise_q;
endmodule

// ==== tb/ismt_top_asserts.sv ====
// Timing checks on the decoder and look-up ports.
// Assumes a single clock domain and the control byte at 0x6e.
`timescale 1ns/1ns
module ismt_checker (
    // Clock and reset
    input wire        clk,
    input wire        resetn,
    // Register port
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata_q,
    // Indirect and counter side
    input wire        ind_strobe_q,
    input wire        ind_write_q,
    input wire [3:0]  ind_port_q,
    input wire [7:0]  ind_offset_q,
    input wire [7:0]  ind_rdata,
    input wire        mib_sel_q,
    input wire [2:0]  mib_port_q,
    input wire [4:0]  mib_index_q,
    // Look-up
    input wire        da_req,
    input wire        sa_req,
    input wire        dyn_hit,
    input wire [4:0]  dyn_ports,
    input wire        fwd_valid_q,
    input wire [4:0]  fwd_ports_q,
    input wire        fwd_from_static_q,
    input wire        fwd_miss_q,
    input wire        sa_dyn_req_q
);
    reg [7:0] ctrl_q;
    wire      trig = reg_wr && reg_addr == 8'h6f;
    wire [2:0] cls = ctrl_q[7:5];

    // Shadow of the control byte; the decode is only visible through it
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            ctrl_q <= 8'h00;
        else if (reg_wr && reg_addr == 8'h6e)
            ctrl_q <= reg_wdata;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_ind_rd;
        ind_strobe_q && !ind_write_q ##1 reg_rd && reg_addr == 8'ha0 && !reg_wr;
    endsequence

    chk_da_answer: assert property (da_req |=> fwd_valid_q)
        else $error("look-up answer missing");
    chk_sa_dyn_only: assert property (sa_req |=> sa_dyn_req_q && !fwd_valid_q)
        else $error("source look-up wrong");
    chk_fwd_hold: assert property (!fwd_valid_q |-> $stable(fwd_ports_q))
        else $error("result moved without request");
    chk_dyn_fallback: assert property (fwd_valid_q && !fwd_from_static_q
        && $past(dyn_hit) |-> fwd_ports_q == $past(dyn_ports) && !fwd_miss_q)
        else $error("dynamic fallback wrong");
    chk_miss_empty: assert property (fwd_valid_q && fwd_miss_q
        |-> fwd_ports_q == 5'h00 && !fwd_from_static_q && !$past(dyn_hit))
        else $error("miss reported wrongly");
    chk_resv_class: assert property (trig && (cls == 3'h3 || cls == 3'h5 || cls == 3'h0)
        |=> !ind_strobe_q)
        else $error("strobe on reserved class");
    chk_eee_decode: assert property (trig && cls == 3'h1 && reg_wdata < 8'h06
        |=> ind_strobe_q && ind_offset_q == $past(reg_wdata)
            && ind_port_q == $past(ctrl_q[3:0]))
        else $error("energy register decode wrong");
    chk_acl_range: assert property (trig && cls == 3'h2
        |=> ind_strobe_q == ($past(reg_wdata) < 8'h20))
        else $error("filter entry range wrong");
    chk_cfg_port: assert property (trig && cls == 3'h4
        |=> ind_strobe_q == ($past(ctrl_q[3:0]) <= 4'h4))
        else $error("config port range wrong");
    chk_mib_map: assert property (trig && cls == 3'h0 && ctrl_q[3:0] == 4'hc
        && reg_wdata < 8'ha0 |=> mib_sel_q && mib_index_q == $past(reg_wdata[4:0])
        && mib_port_q == $past(reg_wdata[7:5]) + 3'h1)
        else $error("counter map wrong");
    chk_byte_capture: assert property (s_ind_rd |=> reg_rdata_q == $past(ind_rdata, 2))
        else $error("indirect read byte lost");
    chk_rsv_bit: assert property (reg_rd && reg_addr == 8'h72 |=> !reg_rdata_q[7])
        else $error("reserved entry bit set");
endmodule

bind ismt_top ismt_checker ismt_checker_inst (.*);

// ==== tb/ismt_top_bench.sv ====
// Self-checking bench for the decoder and static table.
// Assumes ismt_top and the partner model; results are matched against notes.
`timescale 1ns/1ns
module ismt_top_bench;
    logic clk, resetn, reg_wr, reg_rd, da_req, sa_req, dyn_hit, rd_pend;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, ind_rdata, bval;
    logic [47:0] da_mac;
    logic [6:0] da_filter_tag, ta;
    logic [4:0] dyn_ports;
    logic ind_strobe_q, ind_write_q, mib_sel_q, mib_total_q;
    logic [2:0] ind_class_q, mib_port_q;
    logic [3:0] ind_port_q;
    logic [7:0] ind_offset_q, ind_wdata_q;
    logic [4:0] mib_index_q, fwd_ports_q;
    logic fwd_valid_q, fwd_override_q, fwd_from_static_q, fwd_miss_q, sa_dyn_req_q;
    logic [23:0] rd_q[$], ind_q[$], mib_q[$], fwd_q[$], sa_q[$];
    logic [47:0] mac[4];
    logic [63:0] r;
    int seed, errors, n_tests;

    // Every port has a bench signal of the same name and width
    ismt_top ismt_top_inst (.*);
    ismt_partner ismt_partner_inst (.*);

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Empty queue yields unknown, so an unexpected result always mismatches
    function automatic logic [23:0] take(ref logic [23:0] q[$]);
        if (q.size() == 0)
            return 24'hxxxxxx;
        return q.pop_front();
    endfunction

    // Stored write layout or returned read layout of one entry
    function automatic logic [63:0] ent(input logic rl, input logic [6:0] t, input logic u,
        input logic o, input logic v, input logic [4:0] p, input logic [47:0] m);
        return rl ? {t, u, 1'b0, o, v, p, m} : {1'b0, t, u, o, v, p, m};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back({16'h0000, e});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic tg(input logic [7:0] c, input logic [7:0] o);
        wr(8'h6e, c);
        wr(8'h6f, o);
    endtask

    task automatic sw(input logic [7:0] i, input logic [63:0] w);
        for (int k = 0; k < 8; k++) wr(8'h71 + k[7:0], w[63-8*k -: 8]);
        tg(8'h00, i);
    endtask

    task automatic sr(input logic [7:0] i, input logic [63:0] e);
        tg(8'h10, i);
        for (int k = 0; k < 8; k++) rd(8'h71 + k[7:0], e[63-8*k -: 8]);
    endtask

    task automatic lk(input logic [47:0] m, input logic [6:0] t, input logic h,
        input logic [4:0] p, input logic [7:0] e);
        @(posedge clk);
        da_req <= 1'b1;
        da_mac <= m;
        da_filter_tag <= t;
        dyn_hit <= h;
        dyn_ports <= p;
        fwd_q.push_back({16'h0000, e});
        @(posedge clk);
        da_req <= 1'b0;
        dyn_ports <= $random(seed);
    endtask

    // One compare per kind of result, each against the oldest note of its queue
    task automatic cmp_rd;
        cmp("read data", take(rd_q), {16'h0000, reg_rdata_q});
    endtask
    task automatic cmp_ind;
        cmp("indirect", take(ind_q),
            {ind_write_q, ind_class_q, ind_port_q, ind_offset_q, ind_wdata_q});
    endtask
    task automatic cmp_mib;
        cmp("counter", take(mib_q), {mib_port_q, mib_index_q, mib_total_q});
    endtask
    task automatic cmp_fwd;
        cmp("look-up", take(fwd_q),
            {fwd_ports_q, fwd_override_q, fwd_from_static_q, fwd_miss_q});
    endtask
    task automatic cmp_sa;
        cmp("source", take(sa_q), 24'h000001);
    endtask

    // Watcher on the falling edge, where every registered output has settled
    always @(negedge clk) begin
        if (rd_pend) cmp_rd;
        rd_pend = reg_rd;
        if (ind_strobe_q) cmp_ind;
        if (mib_sel_q) cmp_mib;
        if (fwd_valid_q) cmp_fwd;
        if (sa_dyn_req_q) cmp_sa;
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        print_verdict;
    end

    initial begin
        {resetn, reg_wr, reg_rd, da_req, sa_req, dyn_hit} = 6'h00;
        {reg_addr, reg_wdata, da_mac, da_filter_tag, dyn_ports} = 76'h0;
        seed = 39948;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            r = {$random(seed), $random(seed)};
            mac[k] = {k[1:0], r[45:0]};
            ta = r[54:48];
        end
        // Static table: writes, an out-of-range index, read-back layout
        sw(8'h00, ent(0, ta, 1, 1, 1, 5'h1f, mac[0]));
        sw(8'h1f, ent(0, ta, 0, 0, 1, 5'h06, mac[1]));
        sw(8'h05, ent(0, ta, 0, 1, 0, 5'h1f, mac[2]));
        sw(8'h20, ent(0, ta, 0, 0, 1, 5'h10, mac[3]));
        sr(8'h00, ent(1, ta, 1, 1, 1, 5'h1f, mac[0]));
        sr(8'h1f, ent(1, ta, 0, 0, 1, 5'h06, mac[1]));
        // Look-ups: static wins, tag key, invalid entry, fallback, miss
        lk(mac[0], ta, 1, 5'h02, {5'h1f, 3'b110});
        lk(mac[0], ta ^ 7'h01, 0, 5'h02, {5'h00, 3'b001});
        lk(mac[1], ~ta, 1, 5'h08, {5'h06, 3'b010});
        lk(mac[2], ta, 1, 5'h04, {5'h04, 3'b000});
        lk(mac[3], ta, 0, 5'h04, 8'h01);
        @(posedge clk);
        sa_req <= 1'b1;
        sa_q.push_back(24'h000001);
        @(posedge clk);
        sa_req <= 1'b0;
        lk(mac[0], ta, 0, 5'h00, {5'h1f, 3'b110});
        // Port-qualified spaces, the upper edge of each range and the reserved classes
        wr(8'ha0, 8'h3c);
        bval = 8'h3c;
        tg(8'h23, 8'h05);
        ind_q.push_back({1'b1, 3'h1, 4'h3, 8'h05, bval});
        tg(8'h23, 8'h06);
        tg(8'h52, 8'h1f);
        ind_q.push_back({1'b0, 3'h2, 4'h2, 8'h1f, bval});
        rd(8'ha0, 8'h2f ^ 8'h5a);
        bval = 8'h2f ^ 8'h5a;
        tg(8'h52, 8'h20);
        tg(8'h84, 8'h77);
        ind_q.push_back({1'b1, 3'h4, 4'h4, 8'h77, bval});
        tg(8'h90, 8'h01);
        ind_q.push_back({1'b0, 3'h4, 4'h0, 8'h01, bval});
        tg(8'h85, 8'h00);
        tg(8'h61, 8'h00);
        tg(8'ha1, 8'h00);
        // Counter space: first port 3 address, last port address, the totals block
        tg(8'h1c, 8'h40);
        mib_q.push_back({3'h3, 5'h00, 1'b0});
        tg(8'h1c, 8'h9f);
        mib_q.push_back({3'h5, 5'h1f, 1'b0});
        tg(8'h1c, 8'ha0);
        tg(8'h1d, 8'h13);
        mib_q.push_back({3'h0, 5'h13, 1'b1});
        tg(8'h1d, 8'h14);
        // Other table selections must raise nothing
        tg(8'h04, 8'h40);
        tg(8'h18, 8'h40);
        rd(8'h00, 8'h00);
        repeat (4) @(posedge clk);
        cmp("left over", 24'h0, rd_q.size() + ind_q.size() + mib_q.size()
            + fwd_q.size() + sa_q.size());
        print_verdict;
    end
endmodule
